// ---- hw/fsko_top.sv ----
// flash security, backdoor key and option load logic with apb slave
`timescale 1ns/1ps
`include "fsko_params.svh"
module fsko_top
  import fsko_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output fsko_nvreq_t NV_REQ_OUT,
  input wire logic [7:0] NV_DATA_IN,
  input wire fsko_src_t SRC_IN,
  input wire logic RAM_REQ_IN,
  input wire logic BLANK_OK_IN,
  output logic RAM_GRANT_OUT,
  output logic SECURED_OUT
);
  // sequencer and working copies
  fsko_state_t state_q;
  logic [7:0] prot_q; // protection working register
  logic [7:0] opt_q; // option working register
  logic [7:0] cfg_q; // flash config register
  logic [63:0] key_q; // stored backdoor key
  logic [3:0] kidx_q; // key byte index during load
  logic [3:0] wcnt_q; // key bytes written by software
  logic mism_q; // any written byte mismatched
  logic unlock_q; // security disengaged until reset
  logic keyok_q;
  logic keybad_q;
  logic loaded_q;
  logic erase_q; // mass erase seen, awaiting blank
  logic [2:0] nvstep_q; // flash read step (addr then data)
  logic [31:0] rdata_d;
  logic acc, wr, rd_err, lock_field, secured, key_ok_w, key_path;
  logic [7:0] key_byte;
  logic [2:0] kslot; // key byte slot being filled during load

  assign acc = PSEL_IN && PENABLE_IN;
  assign wr = acc && PWRITE_IN;
  // field reads as unsecured only for the one code
  assign lock_field = (opt_q[1:0] != `FSKO_OPT_LOCK_OPEN);
  assign secured = lock_field && !unlock_q;
  // key write path open only with key enable and secure code
  assign key_path = opt_q[`FSKO_OPT_KEY_ENABLE] && cfg_q[`FSKO_CFG_KEY_ACCESS]
                    && SRC_IN.secure_code && !SRC_IN.debug_port;
  assign key_byte = key_q[8*wcnt_q[2:0] +: 8];
  // three-bit wrap keeps the slot in range, so the eighth byte lands in slot seven
  assign kslot = kidx_q[2:0] - 3'h1;
  assign key_ok_w = wr && (PADDR_IN == `FSKO_OFF_KEYWR) && key_path && loaded_q;

  // reset load: protection byte, option byte, then eight key bytes
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      state_q <= FSKO_LOAD_PROT;
      nvstep_q <= 3'h0;
      kidx_q <= 4'h0;
      loaded_q <= 1'b0;
      NV_REQ_OUT <= '0;
    end else begin
      case (state_q)
        FSKO_LOAD_PROT: begin
          // three cycles per read from the flash port: address out at step 0, data taken at step 2
          NV_REQ_OUT <= '{rd: 1'b1, addr: `FSKO_NV_PROT};
          nvstep_q <= nvstep_q + 3'h1;
          if (nvstep_q == 3'h2) begin
            nvstep_q <= 3'h0;
            state_q <= FSKO_LOAD_OPT;
          end
        end
        FSKO_LOAD_OPT: begin
          if (kidx_q == 4'h0) begin
            NV_REQ_OUT <= '{rd: 1'b1, addr: `FSKO_NV_OPT};
          end else begin
            NV_REQ_OUT <= '{rd: 1'b1, addr: `FSKO_NV_KEY_LO + {12'h0, kidx_q - 4'h1}};
          end
          nvstep_q <= nvstep_q + 3'h1;
          if (nvstep_q == 3'h2) begin
            nvstep_q <= 3'h0;
            kidx_q <= kidx_q + 4'h1;
            if (kidx_q == `FSKO_KEY_BYTES) begin
              state_q <= FSKO_IDLE;
              loaded_q <= 1'b1;
              NV_REQ_OUT <= '0;
            end
          end
        end
        FSKO_IDLE: begin
          NV_REQ_OUT <= '0;
        end
        default: begin
          state_q <= FSKO_IDLE;
        end
      endcase
    end
  end

  // capture flash data at the data step of each read
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      prot_q <= 8'hff;
      opt_q <= 8'h00;
      key_q <= 64'h0;
    end else begin
      if (state_q == FSKO_LOAD_PROT && nvstep_q == 3'h2) begin
        prot_q <= NV_DATA_IN;
      end else if (state_q == FSKO_LOAD_OPT && nvstep_q == 3'h2) begin
        if (kidx_q == 4'h0) begin
          opt_q <= NV_DATA_IN;
        end else begin
          key_q[8*kslot +: 8] <= NV_DATA_IN;
        end
      end else if (wr && PADDR_IN == `FSKO_OFF_PROT && loaded_q) begin
        // software may only tighten protection, never loosen it
        prot_q <= prot_q & PWDATA_IN[7:0];
      end
    end
  end

  // config register; reserved bit 4 kept at one whatever is written
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      cfg_q <= `FSKO_CFG_RESET;
    end else if (wr && PADDR_IN == `FSKO_OFF_CFG) begin
      // tolerant of software that breaks the write-one convention
      cfg_q <= (PWDATA_IN[7:0] & `FSKO_CFG_WMASK) | `FSKO_CFG_RESET;
    end
  end

  // backdoor key comparison: eight byte writes then verdict
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      wcnt_q <= 4'h0;
      mism_q <= 1'b0;
      keyok_q <= 1'b0;
      keybad_q <= 1'b0;
    end else if (key_ok_w) begin
      if (wcnt_q == `FSKO_KEY_BYTES - 4'h1) begin
        wcnt_q <= 4'h0;
        mism_q <= 1'b0;
        keyok_q <= !mism_q && (PWDATA_IN[7:0] == key_byte);
        keybad_q <= mism_q || (PWDATA_IN[7:0] != key_byte);
      end else begin
        wcnt_q <= wcnt_q + 4'h1;
        mism_q <= mism_q || (PWDATA_IN[7:0] != key_byte);
        keyok_q <= 1'b0;
        keybad_q <= 1'b0;
      end
    end else begin
      keyok_q <= 1'b0;
      keybad_q <= 1'b0;
    end
  end

  // unlock latch: key match or verified blank after erase, held until reset
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      unlock_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      if (wr && PADDR_IN == `FSKO_OFF_ERASE) begin
        erase_q <= 1'b1; // mass erase requested by any apb write to the erase register, whatever the source
      end
      if (keyok_q && opt_q[`FSKO_OPT_KEY_ENABLE]) begin
        unlock_q <= 1'b1;
      end
      if (erase_q && BLANK_OK_IN) begin
        unlock_q <= 1'b1;
      end
    end
  end

  // ram guard: debug or nonsecure code refused while secured
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      RAM_GRANT_OUT <= 1'b0;
      SECURED_OUT <= 1'b1;
    end else begin
      RAM_GRANT_OUT <= RAM_REQ_IN &&
                       (!secured || (SRC_IN.secure_code && !SRC_IN.debug_port));
      SECURED_OUT <= secured || !loaded_q;
    end
  end

  // read mux; unmapped addresses read zero and raise slave error
  always_comb begin
    rdata_d = 32'h0;
    rd_err = 1'b0;
    case (PADDR_IN)
      `FSKO_OFF_OPT: rdata_d = {24'h0, opt_q};
      `FSKO_OFF_CFG: rdata_d = {24'h0, cfg_q};
      `FSKO_OFF_PROT: rdata_d = {24'h0, prot_q};
      `FSKO_OFF_KEYWR: rdata_d = 32'h0;
      `FSKO_OFF_ERASE: rdata_d = {31'h0, erase_q};
      `FSKO_OFF_STAT: begin
        rdata_d = {28'h0, loaded_q, keybad_q, keyok_q, secured};
      end
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer one cycle after setup: pready in the first access cycle
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      PRDATA_OUT <= 32'h0;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && rd_err;
      PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? rdata_d : 32'h0;
    end
  end

  // the loaded flag rises only with the sequencer idle
  property p_load_order;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      $rose(loaded_q) |-> state_q == FSKO_IDLE;
  endproperty
  a_load_order: assert property (p_load_order) else $error("load order");

  // security field decides secured with no unlock
  property p_lock_field;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (loaded_q && !unlock_q) |-> (secured == (opt_q[1:0] != 2'h2));
  endproperty
  a_lock_field: assert property (p_lock_field) else $error("security field");

  // unlock by key never happens with key enable clear
  property p_key_disabled;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (!opt_q[7] && !erase_q && !unlock_q) |=> !unlock_q;
  endproperty
  a_key_disabled: assert property (p_key_disabled) else $error("key disabled");

  // a debug-port write never counts as a key byte
  property p_key_src;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (wr && SRC_IN.debug_port) |=> $stable(wcnt_q);
  endproperty
  a_key_src: assert property (p_key_src) else $error("key from debug");

  // unlock sticks until reset
  property p_unlock_hold;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      unlock_q |=> unlock_q;
  endproperty
  a_unlock_hold: assert property (p_unlock_hold) else $error("unlock lost");

  // match pulse leads to unlock next cycle
  property p_match_unlock;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (keyok_q && opt_q[7]) |=> unlock_q;
  endproperty
  a_match_unlock: assert property (p_match_unlock) else $error("no unlock");

  // ram refused to debug while secured
  property p_ram_guard;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (secured && SRC_IN.debug_port) |=> !RAM_GRANT_OUT;
  endproperty
  a_ram_guard: assert property (p_ram_guard) else $error("ram leak");

  // blank after erase unlocks next cycle
  property p_erase_unlock;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (erase_q && BLANK_OK_IN) |=> unlock_q;
  endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("erase unlock");

  // config reserved bit one in the cycle after any write
  property p_cfg_rsvd;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      wr ##1 1'b1 |-> cfg_q[4];
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("cfg bit");

  // load steps: data phase of the protection and option fetches, steps 1 and 2 of the key fetches
  sequence s_prot_data;
    state_q == FSKO_LOAD_PROT && nvstep_q == 3'h2;
  endsequence
  sequence s_opt_data;
    state_q == FSKO_LOAD_OPT && nvstep_q == 3'h2 && kidx_q == 4'h0;
  endsequence
  sequence s_key_fetch;
    state_q == FSKO_LOAD_OPT && kidx_q != 4'h0 && nvstep_q != 3'h0;
  endsequence
  // last byte of a key entry that does not match the stored byte
  sequence s_last_bad_byte;
    key_ok_w && wcnt_q == `FSKO_KEY_BYTES - 4'h1 && PWDATA_IN[7:0] != key_byte;
  endsequence

  // protection working copy takes the flash byte at its data step
  property p_prot_load;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s_prot_data |=> prot_q == $past(NV_DATA_IN);
  endproperty
  a_prot_load: assert property (p_prot_load) else $error("protection load");

  // option working copy takes the flash byte at its data step
  property p_opt_load;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s_opt_data |=> opt_q == $past(NV_DATA_IN);
  endproperty
  a_opt_load: assert property (p_opt_load) else $error("option load");

  // key fetches never leave the eight-byte key window
  property p_key_fetch;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s_key_fetch |-> NV_REQ_OUT.rd && NV_REQ_OUT.addr >= `FSKO_NV_KEY_LO
                      && NV_REQ_OUT.addr <= `FSKO_NV_KEY_HI;
  endproperty
  a_key_fetch: assert property (p_key_fetch) else $error("key fetch address");

  // a wrong last byte gives a bad verdict and no match
  property p_key_verdict;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s_last_bad_byte |=> keybad_q && !keyok_q;
  endproperty
  a_key_verdict: assert property (p_key_verdict) else $error("key verdict");

  // a bad verdict leaves security as it was
  property p_bad_keeps;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (keybad_q && !erase_q && !unlock_q) |=> !unlock_q;
  endproperty
  a_bad_keeps: assert property (p_bad_keeps) else $error("bad key unlocked");

  // the part reports secured until the working copies are loaded
  property p_secured_at_load;
    @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      !loaded_q |=> SECURED_OUT;
  endproperty
  a_secured_at_load: assert property (p_secured_at_load) else $error("open before load");
endmodule // fsko_top

// ---- shared/fsko_params.svh ----
// constant definitions for the flash security and option load block
`ifndef FSKO_PARAMS_SVH
`define FSKO_PARAMS_SVH
// register indexes; the offsets are not word aligned, so each register
// sits in a word of its own and its byte address is four times the index
`define FSKO_IDX_OPT 14'h1821
`define FSKO_IDX_CFG 14'h1823
`define FSKO_IDX_PROT 14'h1824
`define FSKO_IDX_KEYWR 14'h1828
`define FSKO_IDX_STAT 14'h182c
`define FSKO_IDX_ERASE 14'h1830
// register byte addresses on the apb slave
`define FSKO_OFF_OPT {`FSKO_IDX_OPT, 2'h0}
`define FSKO_OFF_CFG {`FSKO_IDX_CFG, 2'h0}
`define FSKO_OFF_PROT {`FSKO_IDX_PROT, 2'h0}
`define FSKO_OFF_KEYWR {`FSKO_IDX_KEYWR, 2'h0}
`define FSKO_OFF_STAT {`FSKO_IDX_STAT, 2'h0}
`define FSKO_OFF_ERASE {`FSKO_IDX_ERASE, 2'h0}
// nonvolatile flash addresses
`define FSKO_NV_KEY_LO 16'hffb0
`define FSKO_NV_KEY_HI 16'hffb7
`define FSKO_NV_PROT 16'hffbd
`define FSKO_NV_OPT 16'hffbf
// option byte fields
`define FSKO_OPT_KEY_ENABLE 7
`define FSKO_OPT_LOCK_OPEN 2'h2
// config byte fields
`define FSKO_CFG_KEY_ACCESS 5
`define FSKO_CFG_RSVD 4
`define FSKO_CFG_WMASK 8'h70
`define FSKO_CFG_RESET 8'h10
// status bits
`define FSKO_ST_SECURED 0
`define FSKO_ST_KEYOK 1
`define FSKO_ST_KEYBAD 2
`define FSKO_ST_LOADED 3
`define FSKO_KEY_BYTES 4'h8
`endif

// ---- shared/fsko_pkg.sv ----
// types for the flash security and option load block
package fsko_pkg;
  // load and key sequencer states
  typedef enum logic [1:0] {
    FSKO_LOAD_PROT,
    FSKO_LOAD_OPT,
    FSKO_IDLE
  } fsko_state_t;
  // flash read port request
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } fsko_nvreq_t;
  // access qualifiers from the cpu side
  typedef struct packed {
    logic secure_code;
    logic debug_port;
  } fsko_src_t;
endpackage

// ---- testbench/flash_security_key_option_load_bench.sv ----
// self-checking bench for the flash security, key and option load block
`timescale 1ns/1ps
`include "fsko_params.svh"
module flash_security_key_option_load_bench import fsko_pkg::*; ;
  logic CLOCK_IN;
  logic RESETN_IN;
  logic PSEL_IN;
  logic PENABLE_IN;
  logic PWRITE_IN;
  logic [15:0] PADDR_IN;
  logic [31:0] PWDATA_IN;
  logic [31:0] PRDATA_OUT;
  logic PREADY_OUT;
  logic PSLVERR_OUT;
  fsko_nvreq_t NV_REQ_OUT;
  logic [7:0] NV_DATA_IN = 8'h00;
  fsko_src_t SRC_IN;
  logic RAM_REQ_IN;
  logic BLANK_OK_IN;
  logic RAM_GRANT_OUT;
  logic SECURED_OUT;
  int fails = 0; // mismatches seen
  int checks_done = 0; // comparisons made
  logic [31:0] rd; // last read data
  logic slverr; // last error response
  logic [7:0] nv_opt = 8'h83; // flash option byte, changed per boot
  logic [7:0] nv_prot = 8'h5a; // flash protection byte

  fsko_top i_dut (.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .NV_REQ_OUT(NV_REQ_OUT), .NV_DATA_IN(NV_DATA_IN),
    .SRC_IN(SRC_IN), .RAM_REQ_IN(RAM_REQ_IN), .BLANK_OK_IN(BLANK_OK_IN),
    .RAM_GRANT_OUT(RAM_GRANT_OUT), .SECURED_OUT(SECURED_OUT));

  // 25 mhz clock
  always #20 CLOCK_IN = ~CLOCK_IN;

  // flash contents; key byte i holds c0+i so byte order mistakes show
  function automatic logic [7:0] nv(input logic [15:0] a);
    if (a == `FSKO_NV_PROT) return nv_prot;
    if (a == `FSKO_NV_OPT) return nv_opt;
    if (a >= `FSKO_NV_KEY_LO && a <= `FSKO_NV_KEY_HI) return {5'h18, a[2:0]};
    return 8'h00;
  endfunction

  // flash read port; idle data toggles so a stale sample never looks right
  always @(posedge CLOCK_IN) NV_DATA_IN <= NV_REQ_OUT.rd ? nv(NV_REQ_OUT.addr) : ~NV_DATA_IN;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    PSEL_IN <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLOCK_IN);
    PENABLE_IN <= 1'b1;
    // read data and error are taken at the edge that sees pready high
    do @(posedge CLOCK_IN); while (PREADY_OUT !== 1'b1);
    r = PRDATA_OUT;
    slverr = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge CLOCK_IN);
  endtask

  // settled look at the secured flag
  task automatic lock_chk(input logic exp);
    repeat (2) @(negedge CLOCK_IN);
    chk(32'(SECURED_OUT), 32'(exp));
    @(posedge CLOCK_IN);
  endtask

  // ram request from the current source, grant looked at one cycle later
  task automatic ram(input logic exp);
    RAM_REQ_IN <= 1'b1;
    repeat (2) @(negedge CLOCK_IN);
    chk(32'(RAM_GRANT_OUT), 32'(exp));
    @(posedge CLOCK_IN);
    RAM_REQ_IN <= 1'b0;
    @(posedge CLOCK_IN);
  endtask

  // reset with a given option byte, then poll until the load is done
  task automatic boot(input logic [7:0] opt);
    int n;
    nv_opt = opt;
    RESETN_IN <= 1'b0;
    repeat (4) @(posedge CLOCK_IN);
    chk(32'(SECURED_OUT), 32'h1);
    RESETN_IN <= 1'b1;
    @(posedge CLOCK_IN);
    n = 0;
    rd = '0;
    while (rd[`FSKO_ST_LOADED] !== 1'b1 && n < 40) begin
      apb(1'b0, `FSKO_OFF_STAT, 32'h0, rd);
      n++;
    end
    chk(32'(rd[`FSKO_ST_LOADED]), 32'h1);
  endtask

  // eight key writes, byte 0 first; bad flips a bit of the last byte only
  task automatic keyseq(input logic bad);
    apb(1'b1, `FSKO_OFF_CFG, 32'h30, rd);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `FSKO_OFF_KEYWR, {24'h0, 8'hc0 + 8'(i)} ^ 32'(bad && i == 7), rd);
    end
  endtask

  // hang guard, well beyond the four hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge CLOCK_IN);
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    CLOCK_IN = 1'b0;
    RESETN_IN = 1'b0;
    PSEL_IN = 1'b0;
    PENABLE_IN = 1'b0;
    PWRITE_IN = 1'b0;
    PADDR_IN = '0;
    PWDATA_IN = '0;
    SRC_IN = '{secure_code: 1'b1, debug_port: 1'b0};
    RAM_REQ_IN = 1'b0;
    BLANK_OK_IN = 1'b0;
    @(posedge CLOCK_IN);
    // every security field value; only 2'b10 leaves the part open
    for (int s = 0; s < 4; s++) begin
      boot(8'h80 | 8'(s));
      apb(1'b0, `FSKO_OFF_OPT, 32'h0, rd);
      chk(rd, 32'h80 | 32'(s));
      lock_chk(s != 2);
    end
    boot(8'h83);
    apb(1'b0, `FSKO_OFF_PROT, 32'h0, rd);
    chk(rd, 32'h5a);
    apb(1'b0, `FSKO_OFF_CFG, 32'h0, rd);
    chk(rd, 32'(`FSKO_CFG_RESET));
    // unmapped address answers with an error and zero data
    apb(1'b0, 16'h6100, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(slverr), 32'h1);
    // config write keeps the reserved bit set, as software must, and reads back
    apb(1'b1, `FSKO_OFF_CFG, 32'h50, rd);
    apb(1'b0, `FSKO_OFF_CFG, 32'h0, rd);
    chk(rd, 32'h50);
    // correct key from the debug port is refused, ram stays closed to it
    SRC_IN <= '{secure_code: 1'b1, debug_port: 1'b1};
    keyseq(1'b0);
    lock_chk(1'b1);
    ram(1'b0);
    // code in non-secure memory is refused ram as well
    SRC_IN <= '{secure_code: 1'b0, debug_port: 1'b0};
    ram(1'b0);
    SRC_IN <= '{secure_code: 1'b1, debug_port: 1'b0};
    // one wrong bit in the last byte keeps security
    keyseq(1'b1);
    lock_chk(1'b1);
    // full match opens until reset
    keyseq(1'b0);
    lock_chk(1'b0);
    apb(1'b0, `FSKO_OFF_STAT, 32'h0, rd);
    chk(32'(rd[`FSKO_ST_SECURED]), 32'h0);
    SRC_IN <= '{secure_code: 1'b0, debug_port: 1'b1};
    ram(1'b1);
    SRC_IN <= '{secure_code: 1'b1, debug_port: 1'b0};
    // key disabled: the right key does nothing, only erase plus blank opens
    boot(8'h03);
    keyseq(1'b0);
    lock_chk(1'b1);
    apb(1'b1, `FSKO_OFF_ERASE, 32'h1, rd);
    lock_chk(1'b1);
    BLANK_OK_IN <= 1'b1;
    apb(1'b1, `FSKO_OFF_ERASE, 32'h1, rd);
    lock_chk(1'b0);
    tally_and_finish();
  end

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
endmodule // flash_security_key_option_load_bench
